// >>> rtl/fsq_consts.vh
// Constants for the flash command sequencer with security lock
`ifndef FSQ_CONSTS_VH
`define FSQ_CONSTS_VH

`define FSQ_CTRL_ADDR      16'h0FFF
`define FSQ_FLASH_BASE     16'h1000
`define FSQ_CTRL_EN_MSB    7
`define FSQ_CTRL_EN_LSB    4
`define FSQ_EN_OPEN        4'h3
`define FSQ_EN_LOCKED      4'hC

`define FSQ_UNLOCK_ADDR1   12'h555
`define FSQ_UNLOCK_ADDR2   12'hAAA
`define FSQ_UNLOCK_DATA1   8'hAA
`define FSQ_UNLOCK_DATA2   8'h55
`define FSQ_CODE_PROG      8'hA0
`define FSQ_CODE_ERASE     8'h80
`define FSQ_CODE_SECTOR    8'h30
`define FSQ_CODE_CHIP      8'h10
`define FSQ_CODE_ID_ENTRY  8'h90
`define FSQ_CODE_ID_EXIT   8'hF0
`define FSQ_CODE_SECURE    8'hA5
`define FSQ_SECURE_ADDR    16'hFF7F
`define FSQ_SECURE_DATA    8'h00

`define FSQ_ID_VENDOR_ADDR 16'hF000
`define FSQ_ID_DEVICE_ADDR 16'hF001
`define FSQ_ID_SIZE_ADDR   16'hF002
`define FSQ_LOCKED_CODE    8'h01
`define FSQ_UNLOCKED_CODE  8'h00
`define FSQ_ERASED_BYTE    8'hFF
`define FSQ_TOGGLE_BIT     6

`define FSQ_CLK_MHZ        100
`define FSQ_PROG_TIME_US   40
`define FSQ_LOCK_TIME_US   40
`define FSQ_SECT_TIME_MS   30
`define FSQ_CHIP_TIME_MS   45
`define FSQ_PROG_CYCLES    (`FSQ_PROG_TIME_US * `FSQ_CLK_MHZ)
`define FSQ_LOCK_CYCLES    (`FSQ_LOCK_TIME_US * `FSQ_CLK_MHZ)
`define FSQ_SECT_CYCLES    (`FSQ_SECT_TIME_MS * 1000 * `FSQ_CLK_MHZ)
`define FSQ_CHIP_CYCLES    (`FSQ_CHIP_TIME_MS * 1000 * `FSQ_CLK_MHZ)
`define FSQ_CNT_W          23

`define FSQ_OP_PROG        2'h0
`define FSQ_OP_SECT        2'h1
`define FSQ_OP_CHIP        2'h2
`define FSQ_OP_LOCK        2'h3

`endif

// >>> rtl/fsq_op_timer.v
// Down-counting operation timer for program, erase and lock operations
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"
module fsq_op_timer
(
    input  wire                  sys_clk,
    input  wire                  reset,
    input  wire                  start,
    input  wire [`FSQ_CNT_W-1:0] load,
    output reg                   busy_ff,
    output reg                   done_ff
);
    reg [`FSQ_CNT_W-1:0] count_ff;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_ff <= {`FSQ_CNT_W{1'b0}};
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start && !busy_ff)
            begin
                count_ff <= load;
                busy_ff  <= 1'b1;
            end
            else if (busy_ff)
            begin
                if (count_ff <= {{(`FSQ_CNT_W-1){1'b0}}, 1'b1})
                begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                else
                begin
                    count_ff <= count_ff - {{(`FSQ_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/fsq_sequencer.v
// Flash command sequencer: unlock decoding, operation timing, polling and security lock
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"
module fsq_sequencer
#(
    parameter [`FSQ_CNT_W-1:0] SECT_CYCLES = `FSQ_SECT_CYCLES,
    parameter [`FSQ_CNT_W-1:0] CHIP_CYCLES = `FSQ_CHIP_CYCLES,
    // Identity codes are arbitrary
    parameter [7:0]            ID_VENDOR   = 8'h5A,
    parameter [7:0]            ID_DEVICE   = 8'h3C,
    parameter [7:0]            ID_SIZE     = 8'h0E
)
(
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [15:0] cpu_addr,
    input  wire [7:0]  cpu_wdata,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    output reg  [7:0]  cpu_rdata_ff,
    input  wire [7:0]  arr_rdata,
    output reg         arr_prog_ff,
    output reg         arr_sect_erase_ff,
    output reg         arr_chip_erase_ff,
    output reg  [15:0] arr_waddr_ff,
    output reg  [7:0]  arr_wdata_ff,
    input  wire        serial_mode,
    input  wire        lock_strap,
    output reg         lock_ff,
    output reg         par_read_deny_ff,
    output reg         ser_cmd_deny_ff,
    output reg         flash_block_ff,
    output reg         id_mode_ff
);
    localparam [3:0] ST_IDLE   = 4'h0;
    localparam [3:0] ST_UNL1   = 4'h1;
    localparam [3:0] ST_UNL2   = 4'h2;
    localparam [3:0] ST_PROG   = 4'h3;
    localparam [3:0] ST_ERA1   = 4'h4;
    localparam [3:0] ST_ERA2   = 4'h5;
    localparam [3:0] ST_ERA3   = 4'h6;
    localparam [3:0] ST_SECURE = 4'h7;

    localparam [`FSQ_CNT_W-1:0] PROG_CYCLES = `FSQ_PROG_CYCLES;
    localparam [`FSQ_CNT_W-1:0] LOCK_CYCLES = `FSQ_LOCK_CYCLES;

    reg  [3:0]            state_ff;
    reg  [3:0]            nxt_state;
    reg  [3:0]            cmd_en_ff;
    reg  [1:0]            op_ff;
    reg  [1:0]            nxt_op;
    reg                   toggle_ff;
    reg                   ser_s1_ff;
    reg                   ser_s2_ff;
    reg                   strap_s1_ff;
    reg                   strap_s2_ff;
    reg                   strap_load_ff;
    reg                   start;
    reg  [`FSQ_CNT_W-1:0] load;
    reg                   nxt_prog;
    reg                   nxt_sect;
    reg                   nxt_chip;
    reg                   nxt_id_mode;
    reg  [7:0]            nxt_rdata;
    wire                  busy;
    wire                  done;
    wire                  ctrl_hit;
    wire                  flash_hit;
    wire                  cmd_wr;
    wire [11:0]           low_addr;
    wire                  is_unl1;
    wire                  is_unl2;
    wire                  at_555;
    wire                  write_denied;

    assign ctrl_hit  = (cpu_addr == `FSQ_CTRL_ADDR);
    assign flash_hit = (cpu_addr >= `FSQ_FLASH_BASE);
    assign low_addr  = cpu_addr[11:0];
    assign at_555    = (low_addr == `FSQ_UNLOCK_ADDR1);
    assign is_unl1   = at_555 && (cpu_wdata == `FSQ_UNLOCK_DATA1);
    assign is_unl2   = (low_addr == `FSQ_UNLOCK_ADDR2) && (cpu_wdata == `FSQ_UNLOCK_DATA2);
    // Commands only while enabled and idle
    assign cmd_wr    = cpu_wr && flash_hit && (cmd_en_ff == `FSQ_EN_OPEN) && !busy;
    // Locked serial loader may not program
    assign write_denied = lock_ff && ser_s2_ff;

    fsq_op_timer u_timer
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (start),
        .load    (load),
        .busy_ff (busy),
        .done_ff (done)
    );

    // Command decoder
    always @*
    begin
        nxt_state   = state_ff;
        nxt_op      = op_ff;
        nxt_prog    = 1'b0;
        nxt_sect    = 1'b0;
        nxt_chip    = 1'b0;
        nxt_id_mode = id_mode_ff;
        start       = 1'b0;
        load        = PROG_CYCLES;
        if (cmd_wr)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (is_unl1)
                        nxt_state = ST_UNL1;
                    else if (cpu_wdata == `FSQ_CODE_ID_EXIT)
                        nxt_id_mode = 1'b0;
                end
                ST_UNL1:
                begin
                    nxt_state = is_unl2 ? ST_UNL2 : ST_IDLE;
                end
                ST_UNL2:
                begin
                    nxt_state = ST_IDLE;
                    if (at_555)
                    begin
                        case (cpu_wdata)
                            `FSQ_CODE_PROG:     nxt_state = write_denied ? ST_IDLE : ST_PROG;
                            `FSQ_CODE_ERASE:    nxt_state = ST_ERA1;
                            `FSQ_CODE_SECURE:   nxt_state = ST_SECURE;
                            `FSQ_CODE_ID_ENTRY: nxt_id_mode = 1'b1;
                            `FSQ_CODE_ID_EXIT:  nxt_id_mode = 1'b0;
                            default:            nxt_state = ST_IDLE;
                        endcase
                    end
                end
                ST_PROG:
                begin
                    // Target address is not decoded; all 16 bits of any flash address are taken
                    nxt_state = ST_IDLE;
                    nxt_prog  = 1'b1;
                    nxt_op    = `FSQ_OP_PROG;
                    start     = 1'b1;
                    load      = PROG_CYCLES;
                end
                ST_ERA1:
                begin
                    nxt_state = is_unl1 ? ST_ERA2 : ST_IDLE;
                end
                ST_ERA2:
                begin
                    nxt_state = is_unl2 ? ST_ERA3 : ST_IDLE;
                end
                ST_ERA3:
                begin
                    nxt_state = ST_IDLE;
                    if (cpu_wdata == `FSQ_CODE_SECTOR)
                    begin
                        nxt_sect = 1'b1;
                        nxt_op   = `FSQ_OP_SECT;
                        start    = 1'b1;
                        load     = SECT_CYCLES;
                    end
                    else if (at_555 && cpu_wdata == `FSQ_CODE_CHIP)
                    begin
                        nxt_chip = 1'b1;
                        nxt_op   = `FSQ_OP_CHIP;
                        start    = 1'b1;
                        load     = CHIP_CYCLES;
                    end
                end
                ST_SECURE:
                begin
                    nxt_state = ST_IDLE;
                    if (cpu_addr == `FSQ_SECURE_ADDR && cpu_wdata == `FSQ_SECURE_DATA)
                    begin
                        nxt_op = `FSQ_OP_LOCK;
                        start  = 1'b1;
                        load   = LOCK_CYCLES;
                    end
                end
                default:
                begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
        else if (cpu_wr && flash_hit && !busy)
        begin
            // Disabled command writes drop any partial sequence
            nxt_state = ST_IDLE;
        end
    end

    // Read data selection
    always @*
    begin
        nxt_rdata = 8'h00;
        if (ctrl_hit)
        begin
            nxt_rdata = {cmd_en_ff, 4'h0};
        end
        else if (flash_hit && busy)
        begin
            // Array hidden while busy; only the toggle bit shows
            nxt_rdata[`FSQ_TOGGLE_BIT] = toggle_ff;
        end
        else if (flash_hit && id_mode_ff)
        begin
            case (cpu_addr)
                `FSQ_ID_VENDOR_ADDR: nxt_rdata = ID_VENDOR;
                `FSQ_ID_DEVICE_ADDR: nxt_rdata = ID_DEVICE;
                `FSQ_ID_SIZE_ADDR:   nxt_rdata = ID_SIZE;
                `FSQ_SECURE_ADDR:    nxt_rdata = lock_ff ? `FSQ_LOCKED_CODE
                                                         : `FSQ_UNLOCKED_CODE;
                default:             nxt_rdata = arr_rdata;
            endcase
        end
        else if (flash_hit)
        begin
            nxt_rdata = arr_rdata;
        end
    end

    // Serial mode synchroniser; loader assumes watchdog stopped upstream
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            ser_s1_ff <= 1'b0;
            ser_s2_ff <= 1'b0;
        end
        else
        begin
            ser_s1_ff <= serial_mode;
            ser_s2_ff <= ser_s1_ff;
        end
    end

    // Strap synchroniser runs through reset so the reload sees the pin
    always @(posedge sys_clk)
    begin
        strap_s1_ff <= lock_strap;
        strap_s2_ff <= strap_s1_ff;
    end

    // Sequencer state, control field and lock
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff          <= ST_IDLE;
            cmd_en_ff         <= `FSQ_EN_LOCKED;
            op_ff             <= `FSQ_OP_PROG;
            toggle_ff         <= 1'b1;
            id_mode_ff        <= 1'b0;
            lock_ff           <= 1'b0;
            strap_load_ff     <= 1'b1;
            arr_prog_ff       <= 1'b0;
            arr_sect_erase_ff <= 1'b0;
            arr_chip_erase_ff <= 1'b0;
            arr_waddr_ff      <= 16'h0000;
            arr_wdata_ff      <= 8'h00;
            cpu_rdata_ff      <= 8'h00;
            par_read_deny_ff  <= 1'b0;
            ser_cmd_deny_ff   <= 1'b0;
            flash_block_ff    <= 1'b0;
        end
        else
        begin
            state_ff          <= nxt_state;
            op_ff             <= nxt_op;
            id_mode_ff        <= nxt_id_mode;
            arr_prog_ff       <= nxt_prog;
            arr_sect_erase_ff <= nxt_sect;
            arr_chip_erase_ff <= nxt_chip;
            if (cpu_wr && ctrl_hit)
                cmd_en_ff <= cpu_wdata[`FSQ_CTRL_EN_MSB:`FSQ_CTRL_EN_LSB];
            if (nxt_prog || nxt_sect)
            begin
                arr_waddr_ff <= cpu_addr;
                arr_wdata_ff <= nxt_prog ? cpu_wdata : `FSQ_ERASED_BYTE;
            end
            else if (nxt_chip)
            begin
                arr_waddr_ff <= 16'h0000;
                arr_wdata_ff <= `FSQ_ERASED_BYTE;
            end
            // Polling toggle restarts high for each operation
            if (start)
                toggle_ff <= 1'b1;
            else if (cpu_rd && flash_hit && busy)
                toggle_ff <= ~toggle_ff;
            // Nonvolatile lock reloaded from strap after reset
            if (strap_load_ff)
            begin
                strap_load_ff <= 1'b0;
                lock_ff       <= strap_s2_ff;
            end
            else if (done && op_ff == `FSQ_OP_LOCK)
                lock_ff <= 1'b1;
            else if (done && op_ff == `FSQ_OP_CHIP)
                lock_ff <= 1'b0;
            cpu_rdata_ff     <= cpu_rd ? nxt_rdata : 8'h00;
            par_read_deny_ff <= lock_ff;
            ser_cmd_deny_ff  <= lock_ff && ser_s2_ff;
            flash_block_ff   <= busy || start;
        end
    end
endmodule
`default_nettype wire

// >>> verif/fsq_array_model.sv
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fsq_array_model
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] addr,
    output var  logic [7:0]  rdata,
    input  wire logic        prog,
    input  wire logic        sect_erase,
    input  wire logic        chip_erase,
    input  wire logic [15:0] waddr,
    input  wire logic [7:0]  wdata
);
    logic [7:0] mem [0:65535];
    integer     i;

    initial
    begin
        for (i = 0; i < 65536; i++)
            mem[i] = 8'hFF;
    end

    assign rdata = mem[addr];

    // Programming only clears bits, as real cells do
    always @(posedge sys_clk)
    begin
        if (prog)
            mem[waddr] <= mem[waddr] & wdata;
        if (sect_erase)
            for (i = 0; i < 4096; i++)
                mem[{waddr[15:12], 12'h000} + i] <= 8'hFF;
        if (chip_erase)
            for (i = 0; i < 65536; i++)
                mem[i] <= 8'hFF;
    end
endmodule
`default_nettype wire

// >>> verif/fsq_sequencer_assertions.sv
// Checker for the flash command sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"
module fsq_sequencer_chk
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_rdata_ff,
    input wire logic        arr_prog_ff,
    input wire logic        arr_sect_erase_ff,
    input wire logic        arr_chip_erase_ff,
    input wire logic        lock_ff,
    input wire logic        par_read_deny_ff,
    input wire logic        ser_cmd_deny_ff,
    input wire logic        flash_block_ff
);
    logic                  chip_seen_ff;
    logic [`FSQ_CNT_W-1:0] blk_len_ff;
    logic [1:0]            run_kind_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Remembers a chip erase until a program or sector erase starts
    always @(posedge sys_clk)
    begin
        if (reset)
            chip_seen_ff <= 1'b0;
        else if (arr_chip_erase_ff)
            chip_seen_ff <= 1'b1;
        else if (arr_prog_ff || arr_sect_erase_ff)
            chip_seen_ff <= 1'b0;
    end

    // Length of each blocked run and the operation that opened it
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            blk_len_ff  <= {`FSQ_CNT_W{1'b0}};
            run_kind_ff <= `FSQ_OP_PROG;
        end
        else
        begin
            if (flash_block_ff)
                blk_len_ff <= blk_len_ff + 1'b1;
            else
                blk_len_ff <= {`FSQ_CNT_W{1'b0}};
            if (flash_block_ff && blk_len_ff == {`FSQ_CNT_W{1'b0}})
                run_kind_ff <= arr_prog_ff       ? `FSQ_OP_PROG :
                               arr_sect_erase_ff ? `FSQ_OP_SECT :
                               arr_chip_erase_ff ? `FSQ_OP_CHIP : `FSQ_OP_LOCK;
        end
    end

    a_prog_blocks: assert property (
        arr_prog_ff |-> flash_block_ff) else $error("program pulse without block");
    a_chip_blocks: assert property (
        arr_chip_erase_ff |-> flash_block_ff) else $error("chip erase without block");
    a_busy_masked: assert property (
        $past(cpu_rd) && $past(flash_block_ff) && flash_block_ff
        && $past(cpu_addr[15:12]) != 4'h0 |-> (cpu_rdata_ff & 8'hBF) == 8'h00)
        else $error("array data served while busy");
    a_one_op: assert property (
        $onehot0({arr_prog_ff, arr_sect_erase_ff, arr_chip_erase_ff}))
        else $error("two array operations at once");
    a_prog_length: assert property (
        $fell(flash_block_ff) && run_kind_ff == `FSQ_OP_PROG
        |-> blk_len_ff >= `FSQ_PROG_CYCLES && blk_len_ff <= `FSQ_PROG_CYCLES + 8)
        else $error("program busy time wrong");
    a_lock_sticky: assert property (
        $fell(lock_ff) |-> chip_seen_ff) else $error("lock cleared without chip erase");
    a_deny_follow: assert property (
        par_read_deny_ff == $past(lock_ff)) else $error("parallel deny not following lock");
    a_serial_deny: assert property (
        ser_cmd_deny_ff |-> $past(lock_ff)) else $error("serial deny without lock");
    a_lock_time: assert property (
        $fell(flash_block_ff) && run_kind_ff == `FSQ_OP_LOCK
        |-> lock_ff && blk_len_ff <= `FSQ_LOCK_CYCLES + 1)
        else $error("lock not set in time");

    c_prog: cover property (arr_prog_ff);
    c_sect: cover property (arr_sect_erase_ff);
    c_chip: cover property (arr_chip_erase_ff);
    c_lock: cover property ($rose(lock_ff));
endmodule

bind fsq_sequencer fsq_sequencer_chk i_fsq_sequencer_chk
(
    .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_rdata_ff(cpu_rdata_ff), .arr_prog_ff(arr_prog_ff),
    .arr_sect_erase_ff(arr_sect_erase_ff), .arr_chip_erase_ff(arr_chip_erase_ff),
    .lock_ff(lock_ff), .par_read_deny_ff(par_read_deny_ff),
    .ser_cmd_deny_ff(ser_cmd_deny_ff), .flash_block_ff(flash_block_ff)
);
`default_nettype wire

// >>> verif/test_flash_command_sequencer_security.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"
module test_flash_command_sequencer_security;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic        cpu_wr = 1'b0;
    logic        cpu_rd = 1'b0;
    logic        serial_mode = 1'b0;
    logic        lock_strap = 1'b0;
    wire  [7:0]  cpu_rdata_ff, arr_rdata, arr_wdata_ff;
    wire  [15:0] arr_waddr_ff;
    wire         arr_prog_ff, arr_sect_erase_ff, arr_chip_erase_ff, lock_ff;
    wire         par_read_deny_ff, ser_cmd_deny_ff, flash_block_ff, id_mode_ff;
    integer      mismatches = 0;
    integer      n_compared = 0;

    fsq_sequencer #(.SECT_CYCLES(23'd50), .CHIP_CYCLES(23'd50), .ID_VENDOR(8'hA7))
    i_fsq_sequencer
    (
        .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_ff(cpu_rdata_ff),
        .arr_rdata(arr_rdata), .arr_prog_ff(arr_prog_ff),
        .arr_sect_erase_ff(arr_sect_erase_ff), .arr_chip_erase_ff(arr_chip_erase_ff),
        .arr_waddr_ff(arr_waddr_ff), .arr_wdata_ff(arr_wdata_ff),
        .serial_mode(serial_mode), .lock_strap(lock_strap), .lock_ff(lock_ff),
        .par_read_deny_ff(par_read_deny_ff), .ser_cmd_deny_ff(ser_cmd_deny_ff),
        .flash_block_ff(flash_block_ff), .id_mode_ff(id_mode_ff)
    );

    fsq_array_model i_fsq_array_model
    (
        .sys_clk(sys_clk), .addr(cpu_addr), .rdata(arr_rdata), .prog(arr_prog_ff),
        .sect_erase(arr_sect_erase_ff), .chip_erase(arr_chip_erase_ff),
        .waddr(arr_waddr_ff), .wdata(arr_wdata_ff)
    );

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    task test_done();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge sys_clk);
        cpu_wr    <= 1'b0;
    endtask

    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge sys_clk);
        cpu_rd   <= 1'b0;
        @(negedge sys_clk);
        v = cpu_rdata_ff;
    endtask

    task rdc(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(v, exp);
    endtask

    task unlock(input logic [7:0] code);
        wr(16'hF555, `FSQ_UNLOCK_DATA1);
        wr(16'hFAAA, `FSQ_UNLOCK_DATA2);
        wr(16'hF555, code);
    endtask

    task erase_pre();
        unlock(`FSQ_CODE_ERASE);
        wr(16'hF555, `FSQ_UNLOCK_DATA1);
        wr(16'hFAAA, `FSQ_UNLOCK_DATA2);
    endtask

    // Polls until two reads agree; bounded wait
    task poll(input logic [15:0] a);
        logic [7:0] p, c;
        integer     k;
        rd(a, p);
        check(p, 8'h40);
        for (k = 0; k < 3000; k++)
        begin
            rd(a, c);
            if (c === p)
                return;
            if ((c & 8'hBF) === 8'h00)
                check(c ^ p, 8'h40);
            p = c;
        end
        mismatches++;
        test_done();
    endtask

    initial
    begin
        // Stimulus acts as the RAM-resident program, interrupts off
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rdc(16'h0FFF, 8'hC0);
        unlock(`FSQ_CODE_PROG);
        wr(16'hF000, 8'h00);
        rdc(16'hF000, 8'hFF);
        $display("Test locked field done");
        wr(16'h0FFF, 8'h38);
        rdc(16'h0FFF, 8'h30);
        unlock(`FSQ_CODE_PROG);
        wr(16'hF000, 8'h3F);
        @(negedge sys_clk);
        check({7'h0, flash_block_ff}, 8'h01);
        unlock(`FSQ_CODE_PROG);
        wr(16'hF001, 8'h00);
        poll(16'hF000);
        rdc(16'hF000, 8'h3F);
        rdc(16'hF001, 8'hFF);
        wr(16'hF555, 8'hAA);
        wr(16'hFAAA, 8'h55);
        wr(16'hF555, 8'h77);
        wr(16'hF002, 8'h00);
        rdc(16'hF002, 8'hFF);
        $display("Test program done");
        erase_pre();
        wr(16'hF123, `FSQ_CODE_SECTOR);
        poll(16'hF000);
        rdc(16'hF000, 8'hFF);
        unlock(`FSQ_CODE_SECURE);
        wr(`FSQ_SECURE_ADDR, `FSQ_SECURE_DATA);
        poll(16'hFF7F);
        check({7'h0, lock_ff}, 8'h01);
        check({7'h0, par_read_deny_ff}, 8'h01);
        unlock(`FSQ_CODE_ID_ENTRY);
        rdc(16'hFF7F, 8'h01);
        check({7'h0, id_mode_ff}, 8'h01);
        wr(16'hF000, `FSQ_CODE_ID_EXIT);
        @(negedge sys_clk);
        check({7'h0, id_mode_ff}, 8'h00);
        serial_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({7'h0, ser_cmd_deny_ff}, 8'h01);
        unlock(`FSQ_CODE_PROG);
        wr(16'hF002, 8'h00);
        rdc(16'hF002, 8'hFF);
        serial_mode <= 1'b0;
        repeat (4) @(posedge sys_clk);
        unlock(`FSQ_CODE_PROG);
        wr(16'hF003, 8'h12);
        poll(16'hF003);
        check({7'h0, lock_ff}, 8'h01);
        $display("Test security done");
        erase_pre();
        wr(16'hF555, `FSQ_CODE_CHIP);
        poll(16'hF000);
        check({7'h0, lock_ff}, 8'h00);
        rdc(16'hF003, 8'hFF);
        unlock(`FSQ_CODE_ID_ENTRY);
        rdc(16'hFF7F, 8'h00);
        rdc(16'hF000, 8'hA7);
        unlock(`FSQ_CODE_ID_EXIT);
        @(negedge sys_clk);
        check({7'h0, id_mode_ff}, 8'h00);
        wr(16'h0FFF, 8'hC8);
        rdc(16'h0FFF, 8'hC0);
        $display("Test chip erase done");
        @(posedge sys_clk);
        lock_strap <= 1'b1;
        reset      <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset      <= 1'b0;
        rdc(16'h0FFF, 8'hC0);
        check({7'h0, lock_ff}, 8'h01);
        check({7'h0, par_read_deny_ff}, 8'h01);
        $display("Test strap reload done");
        test_done();
    end
endmodule
`default_nettype wire
